// ===== sasp_port.sv
// Serial async port with smart-card convention handling.
// Assumes one clock, synchronous pins and a strobe register port.
//
// Summary of operation
// - Clock from divider or external pin
// - Clock output rises mid transmitted bit
// - Transmit disable sets empty, resets shifter
// - Receive disable keeps flags and data
// - Card select bit enables card operation
// - Direct convention: LSB first, one is Z
// - Inverse convention: MSB first, one is A
// - Inversion covers data only; parity taken on line data
// - Card frames always carry parity; sense from the mode register
`timescale 1ns/10ps
`default_nettype none

module sasp_port (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire sasp_pkg::sasp_bus_req_t bus,
  output var  logic [7:0]              rdata,
  input  wire logic                    rxd,
  output var  logic                    txd,
  input  wire logic                    sck_in,
  output var  logic                    sck_out,
  output var  logic                    sck_oe_n,
  output var  logic                    irq
);

  sasp_pkg::sasp_port_state_t q;
  sasp_pkg::sasp_port_state_t d;
  logic                       tick;

  // Bit order and data level conversion; self-inverse, so shared by both ways
  function automatic logic [7:0] sasp_conv(input logic [7:0] v,
                                           input logic       msb_first,
                                           input logic       inv);
    logic [7:0] r;
    r = v;
    if (msb_first)
    begin
      for (int i = 0; i < 8; i++)
      begin
        r[i] = v[7 - i];
      end
    end
    if (inv)
    begin
      r = ~r;
    end
    return r;
  endfunction

  // Parity bit for the data as it stands on the line
  function automatic logic sasp_par(input logic [7:0] line_data,
                                    input logic       odd);
    return (^line_data) ^ odd;
  endfunction

  // Sixteen-times tick source
  sasp_baud_tick u_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .divisor (q.div),
    .use_ext (q.ctrl[sasp_pkg::SASP_CTRL_CLK_HI]),
    .sck_in  (sck_in),
    .tick    (tick)
  );

  // Next-state logic
  always_comb
  begin
    logic       te;
    logic       re;
    logic       card;
    logic       msb_first;
    logic       inv;
    logic       odd;
    logic       par_en;
    logic [7:0] line_data;
    logic [7:0] rx_line;
    logic       rx_par;
    logic [7:0] ev;
    logic [7:0] clr;
    te        = q.ctrl[sasp_pkg::SASP_CTRL_TX_EN];
    re        = q.ctrl[sasp_pkg::SASP_CTRL_RX_EN];
    card      = q.card[sasp_pkg::SASP_CARD_SELECT];
    msb_first = card & q.card[sasp_pkg::SASP_CARD_MSB_FIRST];
    inv       = card & q.card[sasp_pkg::SASP_CARD_INVERT];
    odd       = q.mode[sasp_pkg::SASP_MODE_PAR_ODD];
    par_en    = card | q.mode[sasp_pkg::SASP_MODE_PAR_EN];
    line_data = sasp_conv(q.txdata, msb_first, inv);
    rx_line   = q.rx_sh[8:1];
    rx_par    = 1'b0;
    ev        = 8'h00;
    clr       = 8'h00;
    d         = q;
    d.rdata   = 8'h00;

    // Transmit phase counter; its upper bit is the bit-rate clock output
    if (!te)
    begin
      d.tx_ph = 4'h0;
    end
    else if (tick)
    begin
      d.tx_ph = q.tx_ph + 4'h1;
    end

    // Transmitter: shift out one bit per sixteen ticks
    if (!te)
    begin
      d.tx_st   = sasp_pkg::SASP_TX_IDLE;
      d.tx_sh   = 12'hfff;
      d.tx_left = 4'h0;
      ev[sasp_pkg::SASP_ST_TX_EMPTY] = 1'b1;
    end
    else if (tick && q.tx_ph == sasp_pkg::SASP_PH_LAST)
    begin
      case (q.tx_st)
        sasp_pkg::SASP_TX_IDLE:
        begin
          if (!q.status[sasp_pkg::SASP_ST_TX_EMPTY])
          begin
            // Frame: start, data, optional parity, stop bits
            if (par_en)
            begin
              d.tx_sh = {2'b11, sasp_par(line_data, odd), line_data, 1'b0};
              d.tx_left = 4'ha + {3'h0, q.mode[sasp_pkg::SASP_MODE_TWO_STOP]};
            end
            else
            begin
              d.tx_sh = {3'b111, line_data, 1'b0};
              d.tx_left = 4'h9 + {3'h0, q.mode[sasp_pkg::SASP_MODE_TWO_STOP]};
            end
            d.tx_st = sasp_pkg::SASP_TX_SEND;
            ev[sasp_pkg::SASP_ST_TX_EMPTY] = 1'b1;
          end
        end
        sasp_pkg::SASP_TX_SEND:
        begin
          d.tx_sh   = {1'b1, q.tx_sh[11:1]};
          d.tx_left = q.tx_left - 4'h1;
          if (q.tx_left == 4'h1)
          begin
            d.tx_st = sasp_pkg::SASP_TX_IDLE;
          end
        end
        default:
        begin
          d.tx_st = sasp_pkg::SASP_TX_IDLE;
        end
      endcase
    end

    // Receiver: start edge found on a tick, then sample each bit centre
    if (!re)
    begin
      d.rx_st  = sasp_pkg::SASP_RX_IDLE;
      d.rx_ph  = 4'h0;
      d.rx_idx = 4'h0;
    end
    else if (tick)
    begin
      case (q.rx_st)
        sasp_pkg::SASP_RX_IDLE:
        begin
          if (!rxd)
          begin
            d.rx_st  = sasp_pkg::SASP_RX_BUSY;
            d.rx_ph  = 4'h0;
            d.rx_idx = 4'h0;
          end
        end
        sasp_pkg::SASP_RX_BUSY:
        begin
          d.rx_ph = q.rx_ph + 4'h1;
          if (q.rx_ph == sasp_pkg::SASP_PH_CENTRE)
          begin
            if (q.rx_idx == 4'h0)
            begin
              // A start bit gone high by its centre was a glitch
              if (rxd)
              begin
                d.rx_st = sasp_pkg::SASP_RX_IDLE;
              end
              else
              begin
                d.rx_idx = 4'h1;
              end
            end
            else if (q.rx_idx <= sasp_pkg::SASP_RX_DATA_LAST ||
                     (par_en && q.rx_idx == sasp_pkg::SASP_RX_PAR_IDX))
            begin
              d.rx_sh  = {rxd, q.rx_sh[8:1]};
              d.rx_idx = q.rx_idx + 4'h1;
            end
            else
            begin
              // Stop bit: close the character
              d.rx_st = sasp_pkg::SASP_RX_IDLE;
              if (par_en)
              begin
                rx_line = q.rx_sh[7:0];
                rx_par  = q.rx_sh[8];
              end
              if (q.status[sasp_pkg::SASP_ST_RX_FULL])
              begin
                ev[sasp_pkg::SASP_ST_OVERRUN] = 1'b1;
              end
              else
              begin
                d.rxdata = sasp_conv(rx_line, msb_first, inv);
                ev[sasp_pkg::SASP_ST_RX_FULL] = 1'b1;
                ev[sasp_pkg::SASP_ST_FRAMING] = ~rxd;
                ev[sasp_pkg::SASP_ST_PARITY] =
                  par_en & (rx_par != sasp_par(rx_line, odd));
              end
            end
          end
        end
        default:
        begin
          d.rx_st = sasp_pkg::SASP_RX_IDLE;
        end
      endcase
    end

    // Register writes
    if (bus.wr)
    begin
      if (bus.addr == sasp_pkg::SASP_OFS_MODE)
      begin
        d.mode = bus.wdata;
      end
      else if (bus.addr == sasp_pkg::SASP_OFS_DIV)
      begin
        d.div = bus.wdata;
      end
      else if (bus.addr == sasp_pkg::SASP_OFS_CTRL)
      begin
        d.ctrl = bus.wdata;
      end
      else if (bus.addr == sasp_pkg::SASP_OFS_TXDATA)
      begin
        d.txdata = bus.wdata;
        clr[sasp_pkg::SASP_ST_TX_EMPTY] = 1'b1;
      end
      else if (bus.addr == sasp_pkg::SASP_OFS_STATUS)
      begin
        clr = bus.wdata & 8'h78;
      end
      else if (bus.addr == sasp_pkg::SASP_OFS_MASK)
      begin
        d.mask = bus.wdata & 8'hf8;
      end
      else if (bus.addr == sasp_pkg::SASP_OFS_CARD)
      begin
        d.card = bus.wdata & 8'h0d;
      end
    end

    // Sticky flags: an event in the clearing cycle wins
    d.status = ((q.status & ~clr) | ev) & 8'hf8;

    // Register reads; data stands in the following cycle
    if (bus.rd)
    begin
      if (bus.addr == sasp_pkg::SASP_OFS_MODE)
      begin
        d.rdata = q.mode;
      end
      else if (bus.addr == sasp_pkg::SASP_OFS_DIV)
      begin
        d.rdata = q.div;
      end
      else if (bus.addr == sasp_pkg::SASP_OFS_CTRL)
      begin
        d.rdata = q.ctrl;
      end
      else if (bus.addr == sasp_pkg::SASP_OFS_TXDATA)
      begin
        d.rdata = q.txdata;
      end
      else if (bus.addr == sasp_pkg::SASP_OFS_STATUS)
      begin
        d.rdata = q.status;
      end
      else if (bus.addr == sasp_pkg::SASP_OFS_RXDATA)
      begin
        d.rdata = q.rxdata;
      end
      else if (bus.addr == sasp_pkg::SASP_OFS_MASK)
      begin
        d.rdata = q.mask;
      end
      else if (bus.addr == sasp_pkg::SASP_OFS_CARD)
      begin
        d.rdata = q.card;
      end
      else
      begin
        d.rdata = 8'h00;
      end
    end

    // Pins: line idles at one; clock driven only from the internal source
    d.txd      = (d.tx_st == sasp_pkg::SASP_TX_SEND) ? d.tx_sh[0] : 1'b1;
    d.sck_out  = d.tx_ph[3];
    d.sck_oe_n = ~(~d.ctrl[sasp_pkg::SASP_CTRL_CLK_HI] &
                   (d.ctrl[sasp_pkg::SASP_CTRL_CLK_LO] |
                    d.mode[sasp_pkg::SASP_MODE_SYNC]));
    d.irq      = |(d.status & d.mask);
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      q          <= '0;
      q.mode     <= sasp_pkg::SASP_RST_MODE;
      q.div      <= sasp_pkg::SASP_RST_DIV;
      q.ctrl     <= sasp_pkg::SASP_RST_CTRL;
      q.txdata   <= sasp_pkg::SASP_RST_TXDATA;
      q.status   <= sasp_pkg::SASP_RST_STATUS;
      q.rxdata   <= sasp_pkg::SASP_RST_RXDATA;
      q.mask     <= sasp_pkg::SASP_RST_MASK;
      q.card     <= sasp_pkg::SASP_RST_CARD;
      q.tx_st    <= sasp_pkg::SASP_TX_IDLE;
      q.tx_sh    <= 12'hfff;
      q.rx_st    <= sasp_pkg::SASP_RX_IDLE;
      q.txd      <= 1'b1;
      q.sck_oe_n <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state flops
  assign rdata    = q.rdata;
  assign txd      = q.txd;
  assign sck_out  = q.sck_out;
  assign sck_oe_n = q.sck_oe_n;
  assign irq      = q.irq;

endmodule

`default_nettype wire

// ===== sasp_pkg.sv
// Package for the serial async / smart-card port: register map, field
// positions, reset values, state enums and the packed carriers.
// Assumes one 100 MHz clock domain and a plain strobe register port.
package sasp_pkg;

  // Register offsets on the 4-bit register port
  localparam logic [3:0] SASP_OFS_MODE   = 4'h0; // serial_mode_reg
  localparam logic [3:0] SASP_OFS_DIV    = 4'h1; // 16x tick divisor
  localparam logic [3:0] SASP_OFS_CTRL   = 4'h2; // serial_control_reg
  localparam logic [3:0] SASP_OFS_TXDATA = 4'h3; // transmit data
  localparam logic [3:0] SASP_OFS_STATUS = 4'h4; // sticky status, write 1 clears bits 6 to 3
  localparam logic [3:0] SASP_OFS_RXDATA = 4'h5; // rx_data_register
  localparam logic [3:0] SASP_OFS_MASK   = 4'h6; // interrupt mask
  localparam logic [3:0] SASP_OFS_CARD   = 4'h7; // card_mode_reg

  // serial_mode_reg fields
  localparam int unsigned SASP_MODE_SYNC     = 7; // Communication mode bit
  localparam int unsigned SASP_MODE_PAR_EN   = 5; // Parity enable
  localparam int unsigned SASP_MODE_PAR_ODD  = 4; // Odd parity
  localparam int unsigned SASP_MODE_TWO_STOP = 3; // Two stop bits

  // serial_control_reg fields
  localparam int unsigned SASP_CTRL_TX_EN  = 5; // transmit_enable
  localparam int unsigned SASP_CTRL_RX_EN  = 4; // receive_enable
  localparam int unsigned SASP_CTRL_CLK_HI = 1; // clock_source_sel_hi
  localparam int unsigned SASP_CTRL_CLK_LO = 0; // clock_source_sel_lo

  // Status and mask fields
  localparam int unsigned SASP_ST_TX_EMPTY = 7; // tx_buffer_empty_flag
  localparam int unsigned SASP_ST_RX_FULL  = 6; // rx_buffer_full_flag
  localparam int unsigned SASP_ST_OVERRUN  = 5; // overrun_error_flag
  localparam int unsigned SASP_ST_FRAMING  = 4; // framing_error_flag
  localparam int unsigned SASP_ST_PARITY   = 3; // parity_error_flag

  // card_mode_reg fields
  localparam int unsigned SASP_CARD_MSB_FIRST = 3; // bit_order_select
  localparam int unsigned SASP_CARD_INVERT    = 2; // data_level_invert
  localparam int unsigned SASP_CARD_SELECT    = 0; // card_interface_select

  // Reset values
  localparam logic [7:0] SASP_RST_MODE   = 8'h00;
  localparam logic [7:0] SASP_RST_DIV    = 8'hff;
  localparam logic [7:0] SASP_RST_CTRL   = 8'h00;
  localparam logic [7:0] SASP_RST_TXDATA = 8'hff;
  localparam logic [7:0] SASP_RST_STATUS = 8'h80;
  localparam logic [7:0] SASP_RST_RXDATA = 8'h00;
  localparam logic [7:0] SASP_RST_MASK   = 8'h00;
  localparam logic [7:0] SASP_RST_CARD   = 8'h00;

  // Oversampling figures: 16 ticks per bit, sample at the eighth
  localparam logic [3:0] SASP_PH_LAST   = 4'hf;
  localparam logic [3:0] SASP_PH_CENTRE = 4'h7;
  localparam logic [3:0] SASP_RX_DATA_LAST = 4'h8;
  localparam logic [3:0] SASP_RX_PAR_IDX   = 4'h9;

  typedef enum logic {SASP_TX_IDLE, SASP_TX_SEND} sasp_tx_st_t;
  typedef enum logic {SASP_RX_IDLE, SASP_RX_BUSY} sasp_rx_st_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sasp_bus_req_t;

  // Tick generator state
  typedef struct packed {
    logic [7:0] cnt;
    logic       sck_prev;
    logic       tick;
  } sasp_tick_state_t;

  // Port state
  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  div;
    logic [7:0]  ctrl;
    logic [7:0]  txdata;
    logic [7:0]  status;
    logic [7:0]  rxdata;
    logic [7:0]  mask;
    logic [7:0]  card;
    sasp_tx_st_t tx_st;
    logic [11:0] tx_sh;
    logic [3:0]  tx_left;
    logic [3:0]  tx_ph;
    sasp_rx_st_t rx_st;
    logic [3:0]  rx_ph;
    logic [3:0]  rx_idx;
    logic [8:0]  rx_sh;
    logic        txd;
    logic        sck_out;
    logic        sck_oe_n;
    logic        irq;
    logic [7:0]  rdata;
  } sasp_port_state_t;

endpackage

// ===== sasp_baud_tick.sv
// Sixteen-times bit clock source: internal divider or external pin edges.
// Assumes the clock pin level arrives synchronous to clk.
`timescale 1ns/10ps
`default_nettype none

module sasp_baud_tick (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] divisor,
  input  wire logic       use_ext,
  input  wire logic       sck_in,
  output var  logic       tick
);

  sasp_pkg::sasp_tick_state_t q;
  sasp_pkg::sasp_tick_state_t d;

  // One tick per divisor+1 clocks, or per rising edge of the external clock
  always_comb
  begin
    d          = q;
    d.tick     = 1'b0;
    d.sck_prev = sck_in;
    if (use_ext)
    begin
      d.cnt  = 8'h00;
      d.tick = sck_in & ~q.sck_prev;
    end
    else if (q.cnt >= divisor)
    begin
      d.cnt  = 8'h00;
      d.tick = 1'b1;
    end
    else
    begin
      d.cnt = q.cnt + 8'h01;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule

`default_nettype wire

// ===== sasp_port_props.sv
// Checker for the serial port pins and register answers.
// Assumes a bind to sasp_port; sees its ports only.
`timescale 1ns/10ps
`default_nettype none

module sasp_port_props (
  input wire logic                    clk,
  input wire logic                    sys_rst,
  input wire sasp_pkg::sasp_bus_req_t bus,
  input wire logic [7:0]              rdata,
  input wire logic                    txd,
  input wire logic                    sck_out,
  input wire logic                    sck_oe_n,
  input wire logic                    irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Register port answers and interrupt
  rd_quiet_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("rdata not zero outside a read answer");
  unmapped_zero_a: assert property (bus.rd && bus.addr[3] |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  reset_pins_a: assert property ($past(sys_rst) |-> txd && sck_oe_n && !sck_out && !irq)
    else $error("pins not at reset level");
  mask_off_a: assert property (bus.wr && bus.addr == sasp_pkg::SASP_OFS_MASK
      && bus.wdata == 8'h00 |-> ##[1:2] !irq)
    else $error("irq high with mask clear");

  // Clock pin and transmit line
  clk_out_a: assert property (bus.wr && bus.addr == sasp_pkg::SASP_OFS_CTRL
      && bus.wdata[1:0] == 2'b01 |-> ##[1:2] !sck_oe_n)
    else $error("clock pin not driven");
  clk_ext_a: assert property (bus.wr && bus.addr == sasp_pkg::SASP_OFS_CTRL
      && bus.wdata[1] |-> ##[1:2] sck_oe_n)
    else $error("clock pin driven with external clock");
  tx_off_a: assert property (bus.wr && bus.addr == sasp_pkg::SASP_OFS_CTRL
      && !bus.wdata[5] |-> ##[1:2] txd [*3])
    else $error("txd not idle after transmit disable");
  sck_mid_a: assert property ($rose(sck_out) |-> txd == $past(txd, 6)
      ##6 txd == $past(txd, 6))
    else $error("clock rise not inside a steady bit");
endmodule

bind sasp_port sasp_port_props i_sasp_port_props (
  .clk      (clk),
  .sys_rst  (sys_rst),
  .bus      (bus),
  .rdata    (rdata),
  .txd      (txd),
  .sck_out  (sck_out),
  .sck_oe_n (sck_oe_n),
  .irq      (irq)
);
`default_nettype wire

// ===== sasp_peer.sv
// Serial peer model: sends frames on rxd, captures frames from txd.
// Assumes bit time is given in clk cycles; the line idles high.
`timescale 1ns/10ps
`default_nettype none

module sasp_peer (
  input  wire logic clk,
  input  wire logic txd,
  output var  logic rxd
);
  initial rxd = 1'b1;

  // Drive eleven bits, bit 0 first, then release to idle high
  task automatic send(input logic [10:0] f, input int parity_error_flag);
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clk);
      rxd <= f[i];
      repeat (parity_error_flag - 1) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask

  // Wait for a start bit, then sample eleven bits at their centres
  task automatic recv(input int parity_error_flag, output logic [10:0] f, output bit ok);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    ok = (n < 4000);
    repeat (parity_error_flag / 2) @(posedge clk);
    for (int i = 0; i < 11; i++)
    begin
      f[i] = txd;
      repeat (parity_error_flag) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ===== sasp_port_tb.sv
// Testbench for the serial port: registers, framing, card conventions.
// Assumes the port, its checker and the peer model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module sasp_port_tb;
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] card;
    logic [7:0] data;
    logic [7:0] line;
    logic       par;
  } sasp_row_t;

  logic                    clk = 1'b0;
  logic                    sys_rst = 1'b1;
  sasp_pkg::sasp_bus_req_t bus = '0;
  logic [7:0]              rdata;
  logic                    rxd;
  logic                    txd;
  logic                    sck_in;
  logic                    sck_out;
  logic                    sck_oe_n;
  logic                    irq;
  logic [1:0]              sck_cnt = 2'h0;
  int                      bad_count = 0;
  int                      tests_run = 0;
  logic [7:0]              v;
  logic [10:0]             f;
  logic [10:0]             e;
  bit                      ok;
  logic [7:0]              rst_v [9] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h80,
                                         8'h00, 8'h00, 8'h00, 8'h00};
  // Line bits in send order; par holds the stop level where no parity
  sasp_row_t               rows [8] = '{
    '{8'h00, 8'h00, 8'ha5, 8'ha5, 1'b1},
    '{8'h00, 8'h01, 8'h3b, 8'h3b, 1'b1},
    '{8'h10, 8'h0d, 8'h3f, 8'h03, 1'b1},
    '{8'h00, 8'h05, 8'h0f, 8'hf0, 1'b0},
    '{8'h00, 8'h09, 8'h01, 8'h80, 1'b1},
    '{8'h30, 8'h00, 8'h07, 8'h07, 1'b0},
    '{8'h20, 8'h00, 8'h07, 8'h07, 1'b1},
    '{8'h08, 8'h00, 8'h5c, 8'h5c, 1'b1}};

  always #5 clk = ~clk;

  // Free running external clock, period four clk; pin shared with output
  always @(posedge clk) sck_cnt <= sck_cnt + 2'h1;
  assign sck_in = (sck_oe_n !== 1'b0) ? sck_cnt[1] : sck_out;

  sasp_port i_sasp_port (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .bus      (bus),
    .rdata    (rdata),
    .rxd      (rxd),
    .txd      (txd),
    .sck_in   (sck_in),
    .sck_out  (sck_out),
    .sck_oe_n (sck_oe_n),
    .irq      (irq)
  );
  sasp_peer i_sasp_peer (.clk (clk), .txd (txd), .rxd (rxd));

  // Register port cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk(input string n, input logic [10:0] x, input logic [10:0] g);
    tests_run++;
    if (g !== x)
    begin
      $display("Error %s expected %h seen %h", n, x, g);
      bad_count++;
    end
  endtask

  task automatic reg_is(input logic [3:0] a, input logic [7:0] x, input string n);
    rd(a, v);
    chk(n, {3'h0, x}, {3'h0, v});
  endtask

  task automatic cfg(input logic [7:0] m, input logic [7:0] c, input logic [7:0] t);
    wr(sasp_pkg::SASP_OFS_CTRL, 8'h00);
    wr(sasp_pkg::SASP_OFS_MODE, m);
    wr(sasp_pkg::SASP_OFS_CARD, c);
    wr(sasp_pkg::SASP_OFS_CTRL, t);
  endtask

  task automatic get(input int parity_error_flag);
    i_sasp_peer.recv(parity_error_flag, f, ok);
    if (!ok)
    begin
      bad_count++;
      stop_test();
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values, then one unmapped address
    for (int a = 0; a < 9; a++)
      reg_is(a[3:0], rst_v[a], "reset value");
    $display("Reset test done");
    wr(sasp_pkg::SASP_OFS_DIV, 8'h01);
    wr(sasp_pkg::SASP_OFS_MASK, 8'h40);
    // Each row: send, check the line, echo it back, check the receiver
    foreach (rows[i])
    begin
      cfg(rows[i].mode, rows[i].card, 8'h31);
      wr(sasp_pkg::SASP_OFS_TXDATA, rows[i].data);
      get(32);
      e = {1'b1, rows[i].par, rows[i].line, 1'b0};
      chk("tx frame", e, f);
      chk("clock pin drive", 11'h000, {10'h000, sck_oe_n});
      i_sasp_peer.send(e, 32);
      reg_is(sasp_pkg::SASP_OFS_RXDATA, rows[i].data, "rx data");
      chk("irq", 11'h001, {10'h000, irq});
      reg_is(sasp_pkg::SASP_OFS_STATUS, 8'hc0, "status");
      wr(sasp_pkg::SASP_OFS_STATUS, 8'h78);
      $display("Row %0d done", i);
    end
    // External sixteen-times clock on the clock pin
    cfg(8'h00, 8'h00, 8'h32);
    wr(sasp_pkg::SASP_OFS_TXDATA, 8'h5a);
    get(64);
    chk("ext frame", {2'b11, 8'h5a, 1'b0}, f);
    chk("clock pin input", 11'h001, {10'h000, sck_oe_n});
    // Mode bit alone also turns the clock pin into an output
    cfg(8'h80, 8'h00, 8'h30);
    @(posedge clk);
    chk("sync pin drive", 11'h000, {10'h000, sck_oe_n});
    $display("External clock test done");
    // Transmit disabled in mid frame, then a fresh frame
    cfg(8'h00, 8'h00, 8'h31);
    wr(sasp_pkg::SASP_OFS_TXDATA, 8'h00);
    repeat (100) @(posedge clk);
    // Queue a byte so the empty flag is low when transmit is disabled
    wr(sasp_pkg::SASP_OFS_TXDATA, 8'hff);
    wr(sasp_pkg::SASP_OFS_CTRL, 8'h11);
    repeat (3) @(posedge clk);
    chk("txd idle", 11'h001, {10'h000, txd});
    reg_is(sasp_pkg::SASP_OFS_STATUS, 8'h80, "tx empty");
    wr(sasp_pkg::SASP_OFS_CTRL, 8'h31);
    wr(sasp_pkg::SASP_OFS_TXDATA, 8'ha5);
    get(32);
    chk("fresh frame", {2'b11, 8'ha5, 1'b0}, f);
    $display("Transmit abort test done");
    // Slow peer, receiver disable, overrun and interrupt mask
    wr(sasp_pkg::SASP_OFS_MASK, 8'h20);
    i_sasp_peer.send({2'b11, 8'h81, 1'b0}, 33);
    chk("irq masked", 11'h000, {10'h000, irq});
    wr(sasp_pkg::SASP_OFS_CTRL, 8'h21);
    reg_is(sasp_pkg::SASP_OFS_STATUS, 8'hc0, "kept flags");
    reg_is(sasp_pkg::SASP_OFS_RXDATA, 8'h81, "kept data");
    wr(sasp_pkg::SASP_OFS_CTRL, 8'h31);
    i_sasp_peer.send({2'b11, 8'h7e, 1'b0}, 32);
    reg_is(sasp_pkg::SASP_OFS_RXDATA, 8'h81, "overrun data");
    chk("irq set", 11'h001, {10'h000, irq});
    reg_is(sasp_pkg::SASP_OFS_STATUS, 8'he0, "overrun");
    wr(sasp_pkg::SASP_OFS_STATUS, 8'h78);
    reg_is(sasp_pkg::SASP_OFS_STATUS, 8'h80, "cleared");
    chk("irq clear", 11'h000, {10'h000, irq});
    wr(sasp_pkg::SASP_OFS_MASK, 8'h00);
    // Card character with wrong parity
    cfg(8'h00, 8'h01, 8'h31);
    i_sasp_peer.send({2'b10, 8'h3b, 1'b0}, 32);
    reg_is(sasp_pkg::SASP_OFS_STATUS, 8'hc8, "parity error");
    // Plain character with a low stop bit
    wr(sasp_pkg::SASP_OFS_STATUS, 8'h78);
    cfg(8'h00, 8'h00, 8'h31);
    i_sasp_peer.send({2'b10, 8'h55, 1'b0}, 32);
    reg_is(sasp_pkg::SASP_OFS_STATUS, 8'hd0, "framing error");
    reg_is(sasp_pkg::SASP_OFS_RXDATA, 8'h55, "framing data");
    $display("Receive test done");
    // Reset in mid run
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    reg_is(sasp_pkg::SASP_OFS_STATUS, 8'h80, "status after reset");
    reg_is(sasp_pkg::SASP_OFS_CARD, 8'h00, "card after reset");
    $display("Second reset test done");
    stop_test();
  end
endmodule
`default_nettype wire
